// [rtl/sie_irq_status_enable.sv]
// system-management interrupt status, enable and routing block
//
// Functional notes
// - Status a latches port-2 pins 0-2, port-6 pin 0, port-2 pins 4-7.
// - Status b latches port-3 0-3, port-4 1, fan sense, port-4 3, port-6 1.
// - Status c latches port-5 pins 0-7 in bit order.
// - Status d latches port-1 pins 0-7 in bit order.
// - Status bits are readable and a written one clears its bit.
// - Enable a gates parport, serial 2, serial 1, floppy and watchdog.
// - An enable bit of one passes its source, zero blocks it; ring 1 is inverted when RING1_GATE_ACTIVE_LOW is set.
// - Enable b gates mouse, keyboard, two-wire, ring 1, kbd line, ring 2.
// - Enable b bit 6 routes the group to serial irq, bit 7 to the pin.
// - The group output is low, and irq high, only for a latched, unmasked status bit or an enabled peripheral source.
//
// Design decision made here: the AXI4-Lite register port.
`include "sie_regs.svh"
`default_nettype none

module sie_irq_status_enable #(
  parameter int ADDR_W = 8,
  parameter bit RING1_GATE_ACTIVE_LOW = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // event sources
  input wire sie_pkg::sie_pins_t pinLevels,
  input wire sie_pkg::sie_periph_t periphIrq,
  // interrupt outputs
  output logic irq,
  output logic groupSysmgmt_n,
  output logic sysmgmtIrqPin_n,
  output logic serialIrqReq
);
  localparam int IDXW = ADDR_W - 2;
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 8 and 32");
  end
  // ***********************************************************
  // address decode
  // ***********************************************************
  function automatic logic [3:0] regSel(input logic [ADDR_W-1:0] a);
    logic [IDXW-1:0] idx;
    idx = a[ADDR_W-1:2];
    regSel = `SIE_SEL_NONE;
    for (int k = 0; k < 4; k++) begin
      if (idx == IDXW'(`SIE_IDX_STS_A + k)) begin
        regSel = 4'(k);
      end
      if (idx == IDXW'(`SIE_IDX_MSK_A + k)) begin
        regSel = 4'(k + 4);
      end
    end
    if (idx == IDXW'(`SIE_IDX_EN_A)) begin
      regSel = `SIE_SEL_EN_A;
    end
    if (idx == IDXW'(`SIE_IDX_EN_B)) begin
      regSel = `SIE_SEL_EN_B;
    end
  endfunction
  // ***********************************************************
  // pin synchronisers and edge detect
  // ***********************************************************
  // pins are asynchronous: two stages before the edge detector
  logic [31:0] pinMeta_ff;
  logic [31:0] pinSync_ff;
  logic [31:0] pinLast_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      pinLast_ff <= '0;
    end else begin
      pinMeta_ff <= pinLevels;
      pinSync_ff <= pinMeta_ff;
      pinLast_ff <= pinSync_ff;
    end
  end
  // a rising level on a pin is its event
  wire [31:0] pinRise = pinSync_ff & ~pinLast_ff;
  wire [7:0] rawEvt [4];
  assign rawEvt[0] = pinRise[7:0];
  assign rawEvt[1] = pinRise[15:8];
  assign rawEvt[2] = pinRise[23:16];
  assign rawEvt[3] = pinRise[31:24];
  // ***********************************************************
  // axi4-lite write channel
  // ***********************************************************
  logic awHeld_ff;
  logic wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0] wData_ff;
  logic wLane0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  // address and data are latched apart, so either may come first
  assign s_axi_awready = !awHeld_ff;
  assign s_axi_wready = !wHeld_ff;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
  wire [3:0] selW = regSel(awAddr_ff);
  wire wrEn = doWrite && wLane0_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= `SIE_RST_BYTE;
      wLane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SIE_RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata[7:0];
        wLane0_ff <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (selW == `SIE_SEL_NONE) ? `SIE_RESP_SLVERR
                                            : `SIE_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  // ***********************************************************
  // status and mask registers
  // ***********************************************************
  logic [7:0] sts_ff [4];
  logic [7:0] msk_ff [4];
  wire [3:0] stsHit;
  for (genvar i = 0; i < 4; i++) begin : g_sts
    wire wrSts = wrEn && (selW == 4'(i));
    wire wrMsk = wrEn && (selW == 4'(i + 4));
    wire [7:0] clrBits = wrSts ? wData_ff : 8'h00;
    // a new event wins over a clear in the same cycle
    wire [7:0] nxt_sts = (sts_ff[i] & ~clrBits) | rawEvt[i];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sts_ff[i] <= `SIE_RST_BYTE;
        msk_ff[i] <= `SIE_RST_BYTE;
      end else begin
        sts_ff[i] <= nxt_sts;
        if (wrMsk) begin
          msk_ff[i] <= wData_ff;
        end
      end
    end
    assign stsHit[i] = |(sts_ff[i] & msk_ff[i]);
    a_sts_clear_one: assert property (@(posedge clk) disable iff (!rst_n)
      wrSts && wData_ff[0] && !rawEvt[i][0] |=> !sts_ff[i][0])
      else $error("status bit not cleared by a written one");
    a_sts_keep_zero: assert property (@(posedge clk) disable iff (!rst_n)
      wrSts && wData_ff == 8'h00 |=> sts_ff[i] == $past(nxt_sts) &&
      (sts_ff[i] & $past(sts_ff[i])) == $past(sts_ff[i]))
      else $error("status bit lost on a written zero");
  end

  // ***********************************************************
  // enable registers
  // ***********************************************************
  logic [7:0] enA_ff;
  logic [7:0] enB_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enA_ff <= `SIE_RST_BYTE;
      enB_ff <= `SIE_RST_BYTE;
    end else begin
      if (wrEn && selW == `SIE_SEL_EN_A) begin
        enA_ff <= wData_ff & `SIE_ENA_WMASK;
      end
      if (wrEn && selW == `SIE_SEL_EN_B) begin
        enB_ff <= wData_ff;
      end
    end
  end

  // ***********************************************************
  // axi4-lite read channel
  // ***********************************************************
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  assign s_axi_arready = !rvalid_ff;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [3:0] selR = regSel(s_axi_araddr);
  wire [7:0] rdByte = (selR < `SIE_SEL_MSK_BASE) ? sts_ff[selR[1:0]] :
                      (selR < `SIE_SEL_EN_A) ? msk_ff[selR[1:0]] :
                      (selR == `SIE_SEL_EN_A) ? enA_ff :
                      (selR == `SIE_SEL_EN_B) ? enB_ff : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `SIE_RESP_OKAY;
    end else if (arTake) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rdByte};
      rresp_ff <= (selR == `SIE_SEL_NONE) ? `SIE_RESP_SLVERR
                                          : `SIE_RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ***********************************************************
  // gating, group output and routing
  // ***********************************************************
  // ring 1 enable may be wired inverted in some integrations
  wire ring1Gate = RING1_GATE_ACTIVE_LOW ? !enB_ff[`SIE_ENB_RING1]
                                         : enB_ff[`SIE_ENB_RING1];
  wire periphHitA =
    (periphIrq.parport && enA_ff[`SIE_ENA_PARPORT]) ||
    (periphIrq.serial2 && enA_ff[`SIE_ENA_SERIAL2]) ||
    (periphIrq.serial1 && enA_ff[`SIE_ENA_SERIAL1]) ||
    (periphIrq.floppy && enA_ff[`SIE_ENA_FLOPPY]) ||
    (periphIrq.watchdog && enA_ff[`SIE_ENA_WATCHDOG]);
  wire periphHitB =
    (periphIrq.mouse && enB_ff[`SIE_ENB_MOUSE]) ||
    (periphIrq.keyboard && enB_ff[`SIE_ENB_KEYBOARD]) ||
    (periphIrq.twowire && enB_ff[`SIE_ENB_TWOWIRE]) ||
    (periphIrq.ring1 && ring1Gate) ||
    (periphIrq.kbdPortLine && enB_ff[`SIE_ENB_KBDLINE]) ||
    (periphIrq.ring2 && enB_ff[`SIE_ENB_RING2]);
  wire groupNow = (|stsHit) || periphHitA || periphHitB;

  logic group_ff;
  logic pinOut_ff;
  logic serReq_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      group_ff <= 1'b0;
      pinOut_ff <= 1'b0;
      serReq_ff <= 1'b0;
    end else begin
      group_ff <= groupNow;
      pinOut_ff <= groupNow && enB_ff[`SIE_ENB_ROUTE_PIN];
      serReq_ff <= groupNow && enB_ff[`SIE_ENB_ROUTE_SER];
    end
  end

  assign irq = group_ff;
  assign groupSysmgmt_n = !group_ff;
  assign sysmgmtIrqPin_n = !pinOut_ff;
  assign serialIrqReq = serReq_ff;

  // ***********************************************************
  // assertions
  // ***********************************************************
  wire allOff = enA_ff == 8'h00 && enB_ff[5:0] ==
    (RING1_GATE_ACTIVE_LOW ? 6'h08 : 6'h00) && stsHit == 4'h0;

  a_pin_a_map: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pinSync_ff[3]) |=> sts_ff[0][3])
    else $error("port-6 pin 0 event not latched in status a");
  a_fan_map: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pinSync_ff[13]) |=> sts_ff[1][5])
    else $error("fan sense event not latched in status b");
  a_pin_c_map: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pinSync_ff[16]) |=> sts_ff[2][0])
    else $error("port-5 pin 0 event not latched in status c");
  a_pin_d_map: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pinSync_ff[31]) |=> sts_ff[3][7])
    else $error("port-1 pin 7 event not latched in status d");
  a_par_gate: assert property (@(posedge clk) disable iff (!rst_n)
    periphIrq.parport && enA_ff[1] |=> irq)
    else $error("enabled parport source did not raise irq");
  a_mouse_gate: assert property (@(posedge clk) disable iff (!rst_n)
    periphIrq.mouse && enB_ff[0] |=> irq)
    else $error("enabled mouse source did not raise irq");
  a_all_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    allOff |=> !irq && groupSysmgmt_n)
    else $error("group asserted with every source blocked");
  a_pin_route: assert property (@(posedge clk) disable iff (!rst_n)
    !sysmgmtIrqPin_n |-> irq && $past(enB_ff[7]))
    else $error("pin driven without route or group");
  a_ser_route: assert property (@(posedge clk) disable iff (!rst_n)
    serialIrqReq |-> irq && $past(enB_ff[6]))
    else $error("serial request without route or group");
  a_rst_zero: assert property (@(posedge clk)
    !rst_n |-> enA_ff == 8'h00 && enB_ff == 8'h00 &&
    sts_ff[0] == 8'h00 && sts_ff[3] == 8'h00)
    else $error("register not zero during reset");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (enA_ff & ~`SIE_ENA_WMASK) == 8'h00)
    else $error("reserved enable bit set");
  a_ring1_pol: assert property (@(posedge clk) disable iff (!rst_n)
    periphIrq.ring1 && ring1Gate |=> irq)
    else $error("ring 1 source did not raise irq");

  c_write_resp: cover property (@(posedge clk) disable iff (!rst_n)
    doWrite ##1 s_axi_bvalid && s_axi_bready);
  c_irq_rise: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(irq));
  c_clear_on_event: cover property (@(posedge clk) disable iff (!rst_n)
    wrEn && selW == 4'h0 && |(wData_ff & rawEvt[0]));
  c_pin_route: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(sysmgmtIrqPin_n));

endmodule
`default_nettype wire

// [rtl/sie_regs.svh]
// register indices, field positions, reset values and bus codes
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH

// register indices: byte address is four times the index
`define SIE_IDX_STS_A 6'h12
`define SIE_IDX_STS_B 6'h13
`define SIE_IDX_STS_C 6'h14
`define SIE_IDX_STS_D 6'h15
`define SIE_IDX_EN_A 6'h16
`define SIE_IDX_EN_B 6'h17
`define SIE_IDX_MSK_A 6'h18

// internal register selector codes
`define SIE_SEL_MSK_BASE 4'h4
`define SIE_SEL_EN_A 4'h8
`define SIE_SEL_EN_B 4'h9
`define SIE_SEL_NONE 4'hf

// reset value of every register
`define SIE_RST_BYTE 8'h00

// writable bits of enable register a
`define SIE_ENA_WMASK 8'h9e

// enable register a fields
`define SIE_ENA_PARPORT 1
`define SIE_ENA_SERIAL2 2
`define SIE_ENA_SERIAL1 3
`define SIE_ENA_FLOPPY 4
`define SIE_ENA_WATCHDOG 7

// enable register b fields
`define SIE_ENB_MOUSE 0
`define SIE_ENB_KEYBOARD 1
`define SIE_ENB_TWOWIRE 2
`define SIE_ENB_RING1 3
`define SIE_ENB_KBDLINE 4
`define SIE_ENB_RING2 5
`define SIE_ENB_ROUTE_SER 6
`define SIE_ENB_ROUTE_PIN 7

// axi response codes
`define SIE_RESP_OKAY 2'h0
`define SIE_RESP_SLVERR 2'h2

`endif

// [rtl/sie_pkg.sv]
// shared types for the system-management interrupt block
`default_nettype none
package sie_pkg;

  // pin levels, packed so each byte is one status register's sources
  typedef struct packed {
    logic [7:0] port1;
    logic [7:0] port5;
    logic port6Pin1;
    logic port4Pin3;
    logic fanSpeedSenseInput;
    logic port4Pin1;
    logic [3:0] port3;
    logic [3:0] port2Hi;
    logic port6Pin0;
    logic [2:0] port2Lo;
  } sie_pins_t;

  // on-chip peripheral interrupt levels, cleared at their source
  typedef struct packed {
    logic parport;
    logic serial2;
    logic serial1;
    logic floppy;
    logic watchdog;
    logic mouse;
    logic keyboard;
    logic twowire;
    logic ring1;
    logic kbdPortLine;
    logic ring2;
  } sie_periph_t;

endpackage
`default_nettype wire

// [testbench/sie_host_model.sv]
// host chipset model that receives the routed system-management requests
`default_nettype none
module sie_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests from the block
  input wire logic sysmgmtIrqPin_n,
  input wire logic serialIrqReq,
  // what the host has latched
  output logic pinReq,
  output logic serReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // the host samples its request lines once a clock, one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinReq <= 1'b0;
      serReq <= 1'b0;
    end else begin
      pinReq <= !sysmgmtIrqPin_n;
      serReq <= serialIrqReq;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_sysmgmt_irq_status_enable.sv]
// self-checking bench for the system-management interrupt block
`default_nettype none
module tb_sysmgmt_irq_status_enable;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, grpN, pinN, serReq;
  logic pinSeen, serSeen, aGo, wGo, aDone, wDone;
  logic [7:0] awaddr, araddr, r, c;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  sie_pkg::sie_pins_t pins;
  sie_pkg::sie_periph_t periph;
  int fail_count, num_checks, cycles;
  logic [33:0] rdQ[$];
  logic [33:0] bQ[$];
  // gate of each peripheral input: byte address, then bit number
  logic [15:0] gateMap [11] = '{16'h5C05, 16'h5C04, 16'h5C03, 16'h5C02,
    16'h5C01, 16'h5C00, 16'h5807, 16'h5804, 16'h5803, 16'h5802, 16'h5801};
  logic [7:0] routeTab [4] = '{8'h80, 8'h40, 8'hc0, 8'h00};

  sie_irq_status_enable i_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pinLevels(pins), .periphIrq(periph), .irq(irq),
    .groupSysmgmt_n(grpN), .sysmgmtIrqPin_n(pinN), .serialIrqReq(serReq)
  );
  sie_host_model i_host (
    .clk(clk), .rst_n(rst_n), .sysmgmtIrqPin_n(pinN),
    .serialIrqReq(serReq), .pinReq(pinSeen), .serReq(serSeen)
  );

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // generous ceiling: the whole sequence needs about five hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      stop_test();
    end
  end
  // answers are taken at the handshake edge and matched oldest first
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready) begin
      check({rresp, rdata}, rdQ.pop_front());
    end
    if (bvalid === 1'b1 && bready) begin
      check(34'(bresp), bQ.pop_front());
    end
  end

  // ****************************************
  // bus tasks
  // ****************************************
  // no local limit: a dead handshake is ended by the cycle ceiling
  task automatic waitHi(const ref logic s);
    do begin
      @(negedge clk);
    end while (s !== 1'b1);
  endtask
  task automatic waitCk(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] rs = 2'h0);
    bQ.push_back(34'(rs));
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aDone = 1'b0;
    wDone = 1'b0;
    while (!(aDone && wDone)) begin
      @(negedge clk);
      aGo = awvalid && awready;
      wGo = wvalid && wready;
      @(posedge clk);
      if (aGo) begin
        awvalid <= 1'b0;
        aDone = 1'b1;
      end
      if (wGo) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    waitHi(bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [33:0] e);
    rdQ.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    waitHi(arready);
    @(posedge clk);
    arvalid <= 1'b0;
    waitHi(rvalid);
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    pins = '0;
    periph = '0;
    void'($urandom(92783));
    // reset falls after time zero so no flop can miss its edge
    #1 rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      axiRead(8'(8'h48 + 4 * k), 34'(0));
    end
    axiRead(8'h70, 34'h2_0000_0000);
    axiWrite(8'h70, 8'hff, 2'h2);
    axiWrite(8'h58, 8'hff);
    axiRead(8'h58, 34'(8'h9e));
    axiWrite(8'h58, 8'h00);
    // pin events of each status register, masked in afterwards
    for (int k = 0; k < 4; k++) begin
      r = 8'($urandom) | 8'h01;
      c = 8'($urandom);
      @(posedge clk);
      pins[8 * k +: 8] <= r;
      waitCk(6);
      check(34'(irq), 34'(0));
      axiRead(8'(8'h48 + 4 * k), 34'(r));
      pins <= '0;
      axiWrite(8'(8'h60 + 4 * k), 8'hff);
      waitCk(2);
      check(34'({irq, grpN}), 34'(2'b10));
      axiWrite(8'(8'h48 + 4 * k), c);
      axiRead(8'(8'h48 + 4 * k), 34'(r & ~c));
      axiWrite(8'(8'h48 + 4 * k), 8'hff);
      axiRead(8'(8'h48 + 4 * k), 34'(0));
      waitCk(2);
      check(34'(irq), 34'(0));
      axiWrite(8'(8'h60 + 4 * k), 8'h00);
    end
    @(posedge clk);
    pins.fanSpeedSenseInput <= 1'b1;
    waitCk(6);
    axiRead(8'h4C, 34'(8'h20));
    // group output routed to the pin and to the serial stream
    axiWrite(8'h64, 8'h20);
    for (int k = 0; k < 4; k++) begin
      axiWrite(8'h5C, routeTab[k]);
      waitCk(3);
      check(34'({pinN, serReq}), 34'(routeTab[k][7:6] ^ 2'b10));
      check(34'({pinSeen, serSeen}), 34'(routeTab[k][7:6]));
    end
    pins <= '0;
    axiWrite(8'h4C, 8'h20);
    axiWrite(8'h64, 8'h00);
    // each peripheral blocked, then passed by its own gate
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      periph <= sie_pkg::sie_periph_t'(11'h001 << i);
      waitCk(3);
      check(34'(irq), 34'(0));
      axiWrite(gateMap[i][15:8], 8'(8'h01 << gateMap[i][3:0]));
      axiRead(gateMap[i][15:8], 34'(8'h01 << gateMap[i][3:0]));
      waitCk(2);
      check(34'(irq), 34'(1));
      axiWrite(gateMap[i][15:8], 8'h00);
      periph <= '0;
    end
    // a second reset mid-run must clear what software and pins set
    axiWrite(8'h58, 8'h9e);
    @(posedge clk);
    pins <= 32'h0081_0000;
    repeat (6) @(posedge clk);
    pins <= '0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axiRead(8'h50, 34'(0));
    axiRead(8'h58, 34'(0));
    waitCk(4);
    check(34'(rdQ.size() + bQ.size()), 34'(0));
    stop_test();
  end
endmodule
`default_nettype wire
